// ==== verilog/bpc_top.sv ====
// Buck enable, voltage source and page control register bank
// Notes on behaviour
// - Channel A voltage input selector: none, input one, io two, input four.
// - Voltage input passive-to-active picks setting two, active-to-passive picks setting one.
// - Active level of a voltage input comes from its own polarity bit.
// - Channel B voltage input selection works exactly like channel A.
// - Voltage source bit: zero selects setting one, one selects setting two.
// - Pulldown-off bit: zero keeps pull-down while off, one disconnects it.
// - Enable selector: none, input zero, input one, io three; edges switch channel.
// - Channel B enable input selection behaves identically to channel A.
// - On bit: cleared switches channel off, set switches it on.
// - With auto-return set, page field returns to 000 after the access ends.
// - Write mode bit: zero page write, one repeated write on two-wire.
// - Two-wire page map: 00x low 256, 01x 0x100 block, 10x 0x200 block.
// - Four-wire map: 000, 001, 010, 100 each select a 128-register window.
// - Polarity bit zero means active low, one means active high.
module bpc_top
    import bpc_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  reset,
    input  wire logic                  acc_wr,
    input  wire logic                  acc_rd,
    input  wire logic                  acc_done,
    input  wire logic [7:0]            acc_addr,
    input  wire logic [7:0]            acc_wdata,
    input  wire logic                  acc_four_wire,
    input  wire logic [NUM_INPUTS-1:0] gen_inputs,
    input  wire logic [NUM_INPUTS-1:0] input_polarity,
    output logic [7:0]                 acc_rdata,
    output logic                       acc_hit,
    output logic [9:0]                 page_base,
    output logic                       page_valid,
    output logic                       multi_write_repeat,
    output logic                       chan_a_enabled,
    output logic                       chan_b_enabled,
    output logic                       chan_a_use_setting_two,
    output logic                       chan_b_use_setting_two,
    output logic                       chan_a_pulldown_active,
    output logic                       chan_b_pulldown_active
);
    // act keeps the previous sample of each normalised input for edge finding
    typedef struct packed {
        logic [7:0]            buck_a;
        logic [7:0]            buck_b;
        logic [7:0]            page;
        logic [NUM_INPUTS-1:0] act;
        logic                  act_valid;
        logic [7:0]            rdata;
        logic                  hit;
        logic [9:0]            base;
        logic                  base_ok;
        logic                  a_pd;
        logic                  b_pd;
    } bpc_top_s;

    bpc_top_s st_ff;
    bpc_top_s nxt_st;
    logic [NUM_INPUTS-1:0] act_now;
    logic [NUM_INPUTS-1:0] act_prev;
    logic a_on_set;
    logic a_on_clr;
    logic a_src_set;
    logic a_src_clr;
    logic b_on_set;
    logic b_on_clr;
    logic b_src_set;
    logic b_src_clr;

    // Polarity normalises every input to an active flag; zero is active low
    assign act_now  = ~(gen_inputs ^ input_polarity);
    // Before the first sample the previous value equals the current, so no edge
    assign act_prev = st_ff.act_valid ? st_ff.act : act_now;

    // Together the selector fields index five inputs; another count breaks the decode
    if (NUM_INPUTS != 5) begin : g_input_count_check
        $error("bpc_top serves exactly five general inputs");
    end

    bpc_chan u_chan_a (
        .mclk     (mclk),
        .reset    (reset),
        .act_now  (act_now),
        .act_prev (act_prev),
        .ctrl_reg (st_ff.buck_a),
        .on_set   (a_on_set),
        .on_clr   (a_on_clr),
        .src_set  (a_src_set),
        .src_clr  (a_src_clr)
    );

    bpc_chan u_chan_b (
        .mclk     (mclk),
        .reset    (reset),
        .act_now  (act_now),
        .act_prev (act_prev),
        .ctrl_reg (st_ff.buck_b),
        .on_set   (b_on_set),
        .on_clr   (b_on_clr),
        .src_set  (b_src_set),
        .src_clr  (b_src_clr)
    );

    // An input edge overrides the on and source bits of the value handed in
    function automatic logic [7:0] apply_edges(input logic [7:0] r, input logic on_s,
                                               input logic on_c, input logic src_s,
                                               input logic src_c);
        logic [7:0] v;
        v = r;
        if (on_s) begin
            v[ON_BIT] = 1'b1;
        end else if (on_c) begin
            v[ON_BIT] = 1'b0;
        end
        if (src_s) begin
            v[VOLT_SRC_BIT] = 1'b1;
        end else if (src_c) begin
            v[VOLT_SRC_BIT] = 1'b0;
        end
        return v;
    endfunction : apply_edges

    always_comb begin
        nxt_st           = st_ff;
        nxt_st.act       = act_now;
        nxt_st.act_valid = 1'b1;
        nxt_st.hit       = 1'b0;
        // Software write first; an input edge in the same cycle wins over it
        if (acc_wr) begin
            if (acc_addr == BUCK_A_CONTROL_ADDR) begin
                nxt_st.buck_a = acc_wdata & BUCK_CONTROL_MASK;
                nxt_st.hit    = 1'b1;
            end else if (acc_addr == BUCK_B_CONTROL_ADDR) begin
                nxt_st.buck_b = acc_wdata & BUCK_CONTROL_MASK;
                nxt_st.hit    = 1'b1;
            end else if (acc_addr == PAGE_CONTROL_ADDR) begin
                nxt_st.page = acc_wdata & PAGE_CONTROL_MASK;
                nxt_st.hit  = 1'b1;
            end
        end
        // Read data is held until the next read, so a slow host may fetch it late
        if (acc_rd) begin
            if (acc_addr == BUCK_A_CONTROL_ADDR) begin
                nxt_st.rdata = st_ff.buck_a;
                nxt_st.hit   = 1'b1;
            end else if (acc_addr == BUCK_B_CONTROL_ADDR) begin
                nxt_st.rdata = st_ff.buck_b;
                nxt_st.hit   = 1'b1;
            end else if (acc_addr == PAGE_CONTROL_ADDR) begin
                nxt_st.rdata = st_ff.page;
                nxt_st.hit   = 1'b1;
            end else begin
                nxt_st.rdata = 8'h00;
            end
        end
        nxt_st.buck_a = apply_edges(nxt_st.buck_a, a_on_set, a_on_clr,
                                    a_src_set, a_src_clr);
        nxt_st.buck_b = apply_edges(nxt_st.buck_b, b_on_set, b_on_clr,
                                    b_src_set, b_src_clr);
        // Return to page zero at the end of the access, even one that wrote the page
        if (acc_done && st_ff.page[AUTO_RETURN_BIT]) begin
            nxt_st.page[PAGE_HI:PAGE_LO] = PAGE_ZERO;
        end
        // Unmapped page codes leave the base at zero and flag the window invalid
        nxt_st.base_ok = 1'b1;
        if (acc_four_wire) begin
            case (nxt_st.page[PAGE_HI:PAGE_LO])
                3'h0: nxt_st.base = 10'h000;
                3'h1: nxt_st.base = 10'h080;
                3'h2: nxt_st.base = 10'h100;
                3'h4: nxt_st.base = 10'h200;
                default: begin
                    nxt_st.base    = 10'h000;
                    nxt_st.base_ok = 1'b0;
                end
            endcase
        end else begin
            case (nxt_st.page[PAGE_HI:PAGE_LO+1])
                2'h0: nxt_st.base = 10'h000;
                2'h1: nxt_st.base = 10'h100;
                2'h2: nxt_st.base = 10'h200;
                default: begin
                    nxt_st.base    = 10'h000;
                    nxt_st.base_ok = 1'b0;
                end
            endcase
        end
        // Pull-down acts only while the channel is off and not disconnected
        nxt_st.a_pd = !nxt_st.buck_a[ON_BIT] && !nxt_st.buck_a[PD_OFF_BIT];
        nxt_st.b_pd = !nxt_st.buck_b[ON_BIT] && !nxt_st.buck_b[PD_OFF_BIT];
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_ff        <= '0;
            st_ff.buck_a <= BUCK_CONTROL_RST;
            st_ff.buck_b <= BUCK_CONTROL_RST;
            st_ff.page   <= PAGE_CONTROL_RST;
            // Both channels come up off, so their pull-downs are engaged
            st_ff.a_pd   <= 1'b1;
            st_ff.b_pd   <= 1'b1;
            st_ff.base_ok <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Every output is a plain copy of registered state
    assign acc_rdata              = st_ff.rdata;
    assign acc_hit                = st_ff.hit;
    assign page_base              = st_ff.base;
    assign page_valid             = st_ff.base_ok;
    assign multi_write_repeat     = st_ff.page[WRITE_MODE_BIT];
    assign chan_a_enabled         = st_ff.buck_a[ON_BIT];
    assign chan_b_enabled         = st_ff.buck_b[ON_BIT];
    assign chan_a_use_setting_two = st_ff.buck_a[VOLT_SRC_BIT];
    assign chan_b_use_setting_two = st_ff.buck_b[VOLT_SRC_BIT];
    assign chan_a_pulldown_active = st_ff.a_pd;
    assign chan_b_pulldown_active = st_ff.b_pd;
endmodule : bpc_top

// ==== verilog/bpc_pkg.sv ====
// Package for the buck control and page selection register bank
package bpc_pkg;
    localparam logic [7:0] BUCK_A_CONTROL_ADDR = 8'h5d;
    localparam logic [7:0] BUCK_B_CONTROL_ADDR = 8'h5e;
    localparam logic [7:0] PAGE_CONTROL_ADDR   = 8'h80;
    localparam logic [7:0] BUCK_CONTROL_RST    = 8'h00;
    localparam logic [7:0] PAGE_CONTROL_RST    = 8'h00;
    localparam logic [7:0] BUCK_CONTROL_MASK   = 8'h7f;
    localparam logic [7:0] PAGE_CONTROL_MASK   = 8'hc7;
    // Buck control fields
    localparam int VOLT_SEL_HI  = 6;
    localparam int VOLT_SEL_LO  = 5;
    localparam int VOLT_SRC_BIT = 4;
    localparam int PD_OFF_BIT   = 3;
    localparam int EN_SEL_HI    = 2;
    localparam int EN_SEL_LO    = 1;
    localparam int ON_BIT       = 0;
    // Page control fields
    localparam int AUTO_RETURN_BIT = 7;
    localparam int WRITE_MODE_BIT  = 6;
    localparam int PAGE_HI         = 2;
    localparam int PAGE_LO         = 0;
    localparam logic [2:0] PAGE_ZERO = 3'h0;
    // Input vector positions: zero, one, io two, io three, four
    localparam int NUM_INPUTS = 5;
    localparam int IN_ZERO  = 0;
    localparam int IN_ONE   = 1;
    localparam int IO_TWO   = 2;
    localparam int IO_THREE = 3;
    localparam int IN_FOUR  = 4;
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_A    = 2'h1;
    localparam logic [1:0] SEL_B    = 2'h2;
    localparam logic [1:0] SEL_C    = 2'h3;
    localparam logic [9:0] ADDR_WIN_LO_END = 10'h07f;
    localparam logic [9:0] ADDR_WIN_HI_END = 10'h0ff;
endpackage : bpc_pkg

// ==== verilog/bpc_chan.sv ====
// One buck channel: enable and voltage source driven by register and input edges
module bpc_chan
    import bpc_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  reset,
    input  wire logic [NUM_INPUTS-1:0] act_now,
    input  wire logic [NUM_INPUTS-1:0] act_prev,
    input  wire logic [7:0]            ctrl_reg,
    output logic                       on_set,
    output logic                       on_clr,
    output logic                       src_set,
    output logic                       src_clr
);
    typedef struct packed {
        logic on_set;
        logic on_clr;
        logic src_set;
        logic src_clr;
    } bpc_chan_s;

    bpc_chan_s st_ff;
    bpc_chan_s nxt_st;
    logic      en_now;
    logic      en_prev;
    logic      v_now;
    logic      v_prev;
    logic      en_used;
    logic      v_used;

    always_comb begin
        en_used = 1'b1;
        v_used  = 1'b1;
        case (ctrl_reg[EN_SEL_HI:EN_SEL_LO])
            SEL_A: begin
                en_now  = act_now[IN_ZERO];
                en_prev = act_prev[IN_ZERO];
            end
            SEL_B: begin
                en_now  = act_now[IN_ONE];
                en_prev = act_prev[IN_ONE];
            end
            SEL_C: begin
                en_now  = act_now[IO_THREE];
                en_prev = act_prev[IO_THREE];
            end
            default: begin
                en_now  = 1'b0;
                en_prev = 1'b0;
                en_used = 1'b0;
            end
        endcase
        case (ctrl_reg[VOLT_SEL_HI:VOLT_SEL_LO])
            SEL_A: begin
                v_now  = act_now[IN_ONE];
                v_prev = act_prev[IN_ONE];
            end
            SEL_B: begin
                v_now  = act_now[IO_TWO];
                v_prev = act_prev[IO_TWO];
            end
            SEL_C: begin
                v_now  = act_now[IN_FOUR];
                v_prev = act_prev[IN_FOUR];
            end
            default: begin
                v_now  = 1'b0;
                v_prev = 1'b0;
                v_used = 1'b0;
            end
        endcase
        nxt_st.on_set  = en_used && en_now && !en_prev;
        nxt_st.on_clr  = en_used && !en_now && en_prev;
        nxt_st.src_set = v_used && v_now && !v_prev;
        nxt_st.src_clr = v_used && !v_now && v_prev;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign on_set  = st_ff.on_set;
    assign on_clr  = st_ff.on_clr;
    assign src_set = st_ff.src_set;
    assign src_clr = st_ff.src_clr;
endmodule : bpc_chan

// ==== tb/bpc_host_model.sv ====
// Host-side model issuing single-byte register accesses to the bank
module bpc_host_model
    import bpc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic [7:0] acc_rdata,
    input  wire logic       acc_hit,
    output logic            acc_wr,
    output logic            acc_rd,
    output logic            acc_done,
    output logic [7:0]      acc_addr,
    output logic [7:0]      acc_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        acc_wr    = 1'h0;
        acc_rd    = 1'h0;
        acc_done  = 1'h0;
        acc_addr  = 8'h00;
        acc_wdata = 8'h00;
    end
    // Released lines show the inverse, so a design cannot live off stale values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        acc_addr  = a;
        acc_wdata = d;
        acc_wr    = 1'h1;
        @(negedge mclk);
        acc_wr    = 1'h0;
        acc_addr  = ~a;
        acc_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(negedge mclk);
        acc_addr = a;
        acc_rd   = 1'h1;
        @(negedge mclk);
        // The hit flag stands for one cycle only, so take it with the data here
        d = acc_rdata;
        h = acc_hit;
        acc_rd   = 1'h0;
        acc_addr = ~a;
    endtask : rd
    task automatic done_pulse();
        acc_done = 1'h1;
        @(negedge mclk);
        acc_done = 1'h0;
    endtask : done_pulse
endmodule : bpc_host_model

// ==== tb/bpc_top_props.sv ====
// Checker for the buck control and page register bank
module bpc_props
    import bpc_pkg::*;
(
    input wire logic                  mclk,
    input wire logic                  reset,
    input wire logic                  acc_wr,
    input wire logic                  acc_done,
    input wire logic [7:0]            acc_addr,
    input wire logic [7:0]            acc_wdata,
    input wire logic                  acc_four_wire,
    input wire logic [NUM_INPUTS-1:0] gen_inputs,
    input wire logic [NUM_INPUTS-1:0] input_polarity,
    input wire logic [9:0]            page_base,
    input wire logic                  page_valid,
    input wire logic                  multi_write_repeat,
    input wire logic                  chan_a_enabled,
    input wire logic                  chan_a_pulldown_active,
    input wire logic                  chan_b_use_setting_two
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    logic [9:0] prev_ff;
    logic [9:0] prev2_ff;
    logic       quiet;
    logic       wa;
    logic       wb;
    logic       wp;
    always_ff @(posedge mclk) begin
        prev_ff  <= {input_polarity, gen_inputs};
        prev2_ff <= prev_ff;
    end
    // No input change in three samples, so no edge action can collide with a write
    assign quiet = ({input_polarity, gen_inputs} == prev_ff) && (prev_ff == prev2_ff);
    assign wa = acc_wr && acc_addr == BUCK_A_CONTROL_ADDR;
    assign wb = acc_wr && acc_addr == BUCK_B_CONTROL_ADDR;
    assign wp = acc_wr && acc_addr == PAGE_CONTROL_ADDR;
    property p_wr_on;
        wa && quiet && $past(quiet) |=> chan_a_enabled == $past(acc_wdata[ON_BIT]);
    endproperty
    a_wr_on: assert property (p_wr_on) else $error("channel A on bit wrong");
    property p_pd;
        wa && quiet && $past(quiet) |=>
            chan_a_pulldown_active == !($past(acc_wdata[ON_BIT]) || $past(acc_wdata[PD_OFF_BIT]));
    endproperty
    a_pd: assert property (p_pd) else $error("pull-down state wrong");
    property p_src;
        wb && quiet && $past(quiet) |=> chan_b_use_setting_two == $past(acc_wdata[VOLT_SRC_BIT]);
    endproperty
    a_src: assert property (p_src) else $error("channel B source wrong");
    property p_mw;
        wp |=> multi_write_repeat == $past(acc_wdata[WRITE_MODE_BIT]);
    endproperty
    a_mw: assert property (p_mw) else $error("write mode bit wrong");
    property p_page2;
        wp && !acc_wdata[7] && acc_wdata[2:1] == 2'h2 && !acc_four_wire ##1
            !acc_wr && !acc_four_wire |=> page_base == 10'h200 && page_valid;
    endproperty
    a_page2: assert property (p_page2) else $error("two-wire page base wrong");
    property p_page4;
        wp && !acc_wdata[7] && acc_wdata[2:0] == 3'h1 && acc_four_wire ##1
            !acc_wr && acc_four_wire |=> page_base == 10'h080 && page_valid;
    endproperty
    a_page4: assert property (p_page4) else $error("four-wire page base wrong");
    property p_page_auto_return;
        wp && acc_wdata[7] && acc_wdata[2:0] == 3'h4 ##1 acc_done && !acc_wr ##1 !acc_wr
            |=> page_base == 10'h000 && page_valid;
    endproperty
    a_page_auto_return: assert property (p_page_auto_return) else $error("page did not return");
    property p_en_cause;
        $rose(chan_a_enabled) |->
            $past(wa) || !$past(quiet) || !$past(quiet, 2) || !$past(quiet, 3);
    endproperty
    a_en_cause: assert property (p_en_cause) else $error("enable without cause");
    property p_src_cause;
        $changed(chan_b_use_setting_two) |->
            $past(wb) || !$past(quiet) || !$past(quiet, 2) || !$past(quiet, 3);
    endproperty
    a_src_cause: assert property (p_src_cause) else $error("source change without cause");
endmodule : bpc_props
bind bpc_top bpc_props u_props (.mclk, .reset, .acc_wr, .acc_done, .acc_addr, .acc_wdata,
    .acc_four_wire, .gen_inputs, .input_polarity, .page_base, .page_valid, .multi_write_repeat,
    .chan_a_enabled, .chan_a_pulldown_active, .chan_b_use_setting_two);

// ==== tb/tb_top.sv ====
// Self-checking bench for the buck control and page register bank
module tb_top
    import bpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed { logic four; logic [7:0] wd; logic [9:0] base; logic ok; } bpc_row_s;
    localparam bpc_row_s ROWS [14] = '{
        '{1'h0, 8'h00, 10'h000, 1'h1}, '{1'h0, 8'h41, 10'h000, 1'h1}, '{1'h0, 8'h02, 10'h100, 1'h1},
        '{1'h0, 8'h43, 10'h100, 1'h1}, '{1'h0, 8'h04, 10'h200, 1'h1}, '{1'h0, 8'h05, 10'h200, 1'h1},
        '{1'h0, 8'h06, 10'h000, 1'h0}, '{1'h1, 8'h00, 10'h000, 1'h1}, '{1'h1, 8'h01, 10'h080, 1'h1},
        '{1'h1, 8'h42, 10'h100, 1'h1}, '{1'h1, 8'h04, 10'h200, 1'h1}, '{1'h1, 8'h03, 10'h000, 1'h0},
        '{1'h1, 8'h07, 10'h000, 1'h0}, '{1'h1, 8'h05, 10'h000, 1'h0}};
    localparam logic [7:0] BUCK_WD [5] = '{8'h01, 8'h08, 8'h18, 8'hff, 8'h00};
    logic                  mclk, reset, acc_wr, acc_rd, acc_done, acc_four_wire, acc_hit;
    logic                  multi_write_repeat, page_valid, chan_a_enabled, chan_b_enabled;
    logic                  chan_a_use_setting_two, chan_b_use_setting_two, hv, pdx;
    logic                  chan_a_pulldown_active, chan_b_pulldown_active;
    logic [7:0]            acc_addr, acc_wdata, acc_rdata, rdv, ad;
    logic [NUM_INPUTS-1:0] gen_inputs, input_polarity;
    logic [9:0]            page_base;
    int                    err_count, comparisons;
    bpc_top dut (.mclk, .reset, .acc_wr, .acc_rd, .acc_done, .acc_addr, .acc_wdata,
        .acc_four_wire, .gen_inputs, .input_polarity, .acc_rdata, .acc_hit, .page_base,
        .page_valid, .multi_write_repeat, .chan_a_enabled, .chan_b_enabled,
        .chan_a_use_setting_two, .chan_b_use_setting_two, .chan_a_pulldown_active,
        .chan_b_pulldown_active);
    bpc_host_model host (.mclk, .acc_rdata, .acc_hit, .acc_wr, .acc_rd, .acc_done, .acc_addr,
        .acc_wdata);
    initial begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : chk
    task automatic finish_test();
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    function automatic logic pick(input logic ch, input logic v);
        return v ? (ch ? chan_b_use_setting_two : chan_a_use_setting_two)
                 : (ch ? chan_b_enabled : chan_a_enabled);
    endfunction : pick
    task automatic edge_test(input logic ch, input logic v, input logic [1:0] s, input logic pol);
        int idx;
        idx = v ? (s == 2'h1 ? IN_ONE : s == 2'h2 ? IO_TWO : IN_FOUR)
                : (s == 2'h1 ? IN_ZERO : s == 2'h2 ? IN_ONE : IO_THREE);
        ad = ch ? BUCK_B_CONTROL_ADDR : BUCK_A_CONTROL_ADDR;
        host.wr(ad, 8'h00);
        input_polarity      = {NUM_INPUTS{~pol}};
        input_polarity[idx] = pol;
        gen_inputs          = {NUM_INPUTS{~pol}};
        cyc(3);
        host.wr(ad, v ? {1'h0, s, 5'h00} : {5'h00, s, 1'h0});
        gen_inputs[idx] = pol;
        cyc(4);
        chk(10'(pick(ch, v)), 10'(s != 2'h0));
        gen_inputs[idx] = ~pol;
        cyc(4);
        chk(10'(pick(ch, v)), 10'h000);
    endtask : edge_test
    initial begin
        repeat (100000) @(posedge mclk);
        err_count++;
        finish_test();
    end
    initial begin
        reset          = 1'h1;
        gen_inputs     = '0;
        input_polarity = '0;
        acc_four_wire  = 1'h0;
        repeat (5) @(negedge mclk);
        reset = 1'h0;
        cyc(1);
        chk({6'h00, chan_a_pulldown_active, chan_b_pulldown_active, page_valid, chan_a_enabled},
            10'h00e);
        host.rd(8'h5f, rdv, hv);
        chk({hv, 1'h0, rdv}, 10'h000);
        $display("test reset and unmapped read done");
        foreach (ROWS[i]) begin
            acc_four_wire = ROWS[i].four;
            host.wr(PAGE_CONTROL_ADDR, ROWS[i].wd);
            chk(10'(acc_hit), 10'h001);
            cyc(2);
            chk(page_base, ROWS[i].base);
            chk(10'({page_valid, multi_write_repeat}), 10'({ROWS[i].ok, ROWS[i].wd[6]}));
            host.rd(PAGE_CONTROL_ADDR, rdv, hv);
            chk({hv, 1'h0, rdv}, {1'h1, 1'h0, ROWS[i].wd & PAGE_CONTROL_MASK});
        end
        $display("test page map done");
        for (int c = 0; c < 2; c++) begin
            foreach (BUCK_WD[j]) begin
                ad = c[0] ? BUCK_B_CONTROL_ADDR : BUCK_A_CONTROL_ADDR;
                host.wr(ad, BUCK_WD[j]);
                cyc(1);
                pdx = c[0] ? chan_b_pulldown_active : chan_a_pulldown_active;
                chk(10'(pick(c[0], 1'h0)), 10'(BUCK_WD[j][ON_BIT]));
                chk(10'(pick(c[0], 1'h1)), 10'(BUCK_WD[j][VOLT_SRC_BIT]));
                chk(10'(pdx), 10'(!(BUCK_WD[j][ON_BIT] || BUCK_WD[j][PD_OFF_BIT])));
                host.rd(ad, rdv, hv);
                chk({hv, 1'h0, rdv}, {1'h1, 1'h0, BUCK_WD[j] & BUCK_CONTROL_MASK});
            end
        end
        $display("test channel registers done");
        for (int k = 0; k < 16; k++) begin
            edge_test(k[0], k[1], k[3:2], 1'h0);
            edge_test(k[0], k[1], k[3:2], 1'h1);
        end
        $display("test input edges done");
        acc_four_wire = 1'h1;
        host.wr(PAGE_CONTROL_ADDR, 8'h84);
        cyc(3);
        chk(page_base, 10'h200);
        host.wr(PAGE_CONTROL_ADDR, 8'h84);
        host.done_pulse();
        cyc(2);
        chk(10'(page_valid), 10'h001);
        chk(page_base, 10'h000);
        host.rd(PAGE_CONTROL_ADDR, rdv, hv);
        chk({2'h0, rdv}, 10'h080);
        $display("test page return done");
        finish_test();
    end
endmodule : tb_top
